// [logic/lspc_top.sv]
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps


module lspc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        output_force_off_i,
    input  wire logic        register_latch_strobe_i,
    input  wire logic        serial_shift_clock_i,
    input  wire logic        serial_in_pin_i,
    input  wire logic        pwm_reference_clock_i,
    input  wire logic        dot_correction_source_select_i,
    input  wire logic [1:0]  mode_program_select_i,
    input  wire logic        open_led_detect_i,
    input  wire logic        thermal_error_flag_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [31:0] reg_rdata_o,
    output logic             irq_o,
    output logic             serial_out_pin_o,
    output logic      [15:0] channel_sink_output_o,
    output logic      [95:0] dot_correction_scale_o,
    output logic             error_flag_output_o,
    output logic             error_flag_output_oe_n_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [lspc_pkg::GS_W-1:0] gs_slice(input logic [lspc_pkg::GS_BITS-1:0] v,
                                                         input int ch);
        gs_slice = v[ch*lspc_pkg::GS_W +: lspc_pkg::GS_W];
    endfunction

    function automatic logic [lspc_pkg::DC_W-1:0] dc_slice(input logic [lspc_pkg::DC_BITS-1:0] v,
                                                         input int ch);
        dc_slice = v[ch*lspc_pkg::DC_W +: lspc_pkg::DC_W];
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    lspc_pkg::lspc_pins_type pins_raw;
    lspc_pkg::lspc_pins_type pins;

    assign pins_raw.force_off = output_force_off_i;
    assign pins_raw.latch     = register_latch_strobe_i;
    assign pins_raw.shift_clk = serial_shift_clock_i;
    assign pins_raw.serial_in = serial_in_pin_i;
    assign pins_raw.pwm_clk   = pwm_reference_clock_i;
    assign pins_raw.dc_source = dot_correction_source_select_i;
    assign pins_raw.mode_pin  = mode_program_select_i;
    assign pins_raw.open_led  = open_led_detect_i;
    assign pins_raw.thermal   = thermal_error_flag_i;

    lspc_sync #(
        .WIDTH ($bits(lspc_pkg::lspc_pins_type))
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pins_raw),
        .q_o   (pins)
    );

    // ------------------------------------------------------------
    // Edge detection on the synchronised clocks
    // ------------------------------------------------------------
    // Both link clocks are sampled by clk_i, so each must stay high and low
    // for at least two clk_i periods for an edge to be seen.
    logic shift_clk_q;
    logic pwm_clk_q;
    logic open_led_q;
    logic thermal_q;
    logic shift_rise;
    logic pwm_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_clk_q <= 1'b0;
            pwm_clk_q   <= 1'b0;
            open_led_q  <= 1'b0;
            thermal_q   <= 1'b0;
        end else begin
            shift_clk_q <= pins.shift_clk;
            pwm_clk_q   <= pins.pwm_clk;
            open_led_q  <= pins.open_led;
            thermal_q   <= pins.thermal;
        end
    end

    assign shift_rise = pins.shift_clk & ~shift_clk_q;
    assign pwm_rise   = pins.pwm_clk & ~pwm_clk_q;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    lspc_pkg::lspc_mode_type mode;

    always_comb begin
        unique case (pins.mode_pin)
            lspc_pkg::MODE_PIN_GROUND: mode = lspc_pkg::LSPC_MODE_GS;
            lspc_pkg::MODE_PIN_SUPPLY: mode = lspc_pkg::LSPC_MODE_DC;
            lspc_pkg::MODE_PIN_PROG:   mode = lspc_pkg::LSPC_MODE_PROG;
            // The unused level code is taken as ground, the safest mode.
            default:                   mode = lspc_pkg::LSPC_MODE_GS;
        endcase
    end

    // ------------------------------------------------------------
    // Input shift register
    // ------------------------------------------------------------
    logic [lspc_pkg::GS_BITS-1:0] shift_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg <= '0;
        end else if (shift_rise) begin
            shift_reg <= {shift_reg[lspc_pkg::GS_BITS-2:0], pins.serial_in};
        end
    end

    // The cascade tap sits at the end of the frame that the mode uses, so
    // a chain of devices sees the correct bit count per device.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_pin_o <= 1'b0;
        end else if (mode == lspc_pkg::LSPC_MODE_GS) begin
            serial_out_pin_o <= shift_reg[lspc_pkg::GS_BITS-1];
        end else begin
            serial_out_pin_o <= shift_reg[lspc_pkg::DC_BITS-1];
        end
    end

    // ------------------------------------------------------------
    // Grayscale and dot correction registers
    // ------------------------------------------------------------
    logic [lspc_pkg::GS_BITS-1:0] gs_reg;
    logic [lspc_pkg::DC_BITS-1:0] dc_reg;
    logic                         gs_load;
    logic                         dc_load;

    assign gs_load = pins.latch & (mode == lspc_pkg::LSPC_MODE_GS);
    assign dc_load = pins.latch & (mode != lspc_pkg::LSPC_MODE_GS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gs_reg <= {lspc_pkg::NUM_CH{lspc_pkg::GS_RESET}};
        end else if (gs_load) begin
            gs_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dc_reg <= {lspc_pkg::NUM_CH{lspc_pkg::DC_RESET}};
        end else if (dc_load) begin
            dc_reg <= shift_reg[lspc_pkg::DC_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // EEPROM image
    // ------------------------------------------------------------
    // Held in flip-flops, so the stored image is lost at rst_i; a real
    // nonvolatile cell would keep it.
    logic [lspc_pkg::DC_BITS-1:0] eeprom;
    logic                         eeprom_write;

    assign eeprom_write = (mode == lspc_pkg::LSPC_MODE_PROG) & pins.dc_source;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eeprom <= {lspc_pkg::NUM_CH{lspc_pkg::DC_EEPROM_DEFAULT}};
        end else if (eeprom_write) begin
            eeprom <= dc_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dot_correction_scale_o <= {lspc_pkg::NUM_CH{lspc_pkg::DC_EEPROM_DEFAULT}};
        end else begin
            for (int ch = 0; ch < lspc_pkg::NUM_CH; ch++) begin
                if (pins.dc_source) begin
                    dot_correction_scale_o[ch*lspc_pkg::DC_W +: lspc_pkg::DC_W] <= dc_slice(dc_reg, ch);
                end else begin
                    dot_correction_scale_o[ch*lspc_pkg::DC_W +: lspc_pkg::DC_W] <= dc_slice(eeprom, ch);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Grayscale PWM
    // ------------------------------------------------------------
    logic [lspc_pkg::GS_W-1:0] pwm_cnt;
    logic                      pwm_wrap;

    assign pwm_wrap = pwm_rise & (&pwm_cnt) & ~pins.force_off;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_cnt <= lspc_pkg::PWM_CNT_RESET;
        end else if (pins.force_off) begin
            pwm_cnt <= lspc_pkg::PWM_CNT_RESET;
        end else if (pwm_rise) begin
            pwm_cnt <= pwm_cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_sink_output_o <= '0;
        end else begin
            for (int ch = 0; ch < lspc_pkg::NUM_CH; ch++) begin
                if (pins.force_off) begin
                    channel_sink_output_o[ch] <= 1'b0;
                end else begin
                    channel_sink_output_o[ch] <= (pwm_cnt < gs_slice(gs_reg, ch));
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Error output
    // ------------------------------------------------------------
    // The pad only ever drives low, so the data flop stays at zero and the
    // fault level goes out through the enable alone.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_flag_output_o      <= 1'b0;
            error_flag_output_oe_n_o <= 1'b1;
        end else begin
            error_flag_output_o      <= 1'b0;
            error_flag_output_oe_n_o <= ~(pins.open_led | pins.thermal);
        end
    end

    // ------------------------------------------------------------
    // Event status, enable and interrupt
    // ------------------------------------------------------------
    logic [lspc_pkg::EV_W-1:0] events;
    logic [lspc_pkg::EV_W-1:0] status;
    logic [lspc_pkg::EV_W-1:0] enable;
    logic [lspc_pkg::EV_W-1:0] clear_req;
    logic                      gs_load_q;
    logic                      dc_load_q;
    logic                      eeprom_write_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gs_load_q      <= 1'b0;
            dc_load_q      <= 1'b0;
            eeprom_write_q <= 1'b0;
        end else begin
            gs_load_q      <= gs_load;
            dc_load_q      <= dc_load;
            eeprom_write_q <= eeprom_write;
        end
    end

    always_comb begin
        events                           = '0;
        events[lspc_pkg::EV_OPEN_LED]    = pins.open_led & ~open_led_q;
        events[lspc_pkg::EV_THERMAL]     = pins.thermal & ~thermal_q;
        events[lspc_pkg::EV_GS_LATCH]    = gs_load & ~gs_load_q;
        events[lspc_pkg::EV_DC_LATCH]    = dc_load & ~dc_load_q;
        events[lspc_pkg::EV_EEPROM_WR]   = eeprom_write & ~eeprom_write_q;
        events[lspc_pkg::EV_PWM_WRAP]    = pwm_wrap;
    end

    assign clear_req = (reg_write_i && reg_addr_i == lspc_pkg::OFS_CLEAR) ?
                       reg_wdata_i[lspc_pkg::EV_W-1:0] : '0;

    // A new event in the same cycle as its clear keeps the bit set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~clear_req) | events;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable <= '0;
        end else if (reg_write_i && reg_addr_i == lspc_pkg::OFS_ENABLE) begin
            enable <= reg_wdata_i[lspc_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((status & ~clear_req) | events) & enable);
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= '0;
            if (reg_read_i) begin
                unique case (reg_addr_i)
                    lspc_pkg::OFS_STATUS: begin
                        reg_rdata_o[lspc_pkg::EV_W-1:0] <= status;
                    end
                    lspc_pkg::OFS_ENABLE: begin
                        reg_rdata_o[lspc_pkg::EV_W-1:0] <= enable;
                    end
                    lspc_pkg::OFS_STATE: begin
                        reg_rdata_o[lspc_pkg::STATE_CNT_POS +: lspc_pkg::GS_W] <= pwm_cnt;
                        reg_rdata_o[lspc_pkg::STATE_MODE_POS +: 3]             <= mode;
                        reg_rdata_o[lspc_pkg::STATE_BLANK_POS]                 <= pins.force_off;
                    end
                    default: begin
                        reg_rdata_o <= '0;
                    end
                endcase
            end
        end
    end

endmodule // lspc_top

// [logic/lspc_pkg.sv]
package lspc_pkg;

    // ------------------------------------------------------------
    // Channel geometry
    // ------------------------------------------------------------
    localparam int NUM_CH  = 16;
    localparam int GS_W    = 12;
    localparam int DC_W    = 6;
    localparam int GS_BITS = NUM_CH * GS_W;
    localparam int DC_BITS = NUM_CH * DC_W;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [GS_W-1:0] GS_RESET          = 12'h000;
    localparam logic [DC_W-1:0] DC_RESET          = 6'h00;
    localparam logic [DC_W-1:0] DC_EEPROM_DEFAULT = 6'h3f;
    localparam logic [GS_W-1:0] PWM_CNT_RESET     = 12'h000;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CLEAR  = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_STATE  = 8'h0c;

    // ------------------------------------------------------------
    // Event bit positions, shared by status, clear and enable
    // ------------------------------------------------------------
    localparam int EV_OPEN_LED  = 0;
    localparam int EV_THERMAL   = 1;
    localparam int EV_GS_LATCH  = 2;
    localparam int EV_DC_LATCH  = 3;
    localparam int EV_EEPROM_WR = 4;
    localparam int EV_PWM_WRAP  = 5;
    localparam int EV_W         = 6;

    // ------------------------------------------------------------
    // State register field positions
    // ------------------------------------------------------------
    localparam int STATE_CNT_POS   = 0;
    localparam int STATE_MODE_POS  = 16;
    localparam int STATE_BLANK_POS = 20;

    // ------------------------------------------------------------
    // Level codes of the three-level mode pin
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_PIN_GROUND = 2'h0;
    localparam logic [1:0] MODE_PIN_SUPPLY = 2'h1;
    localparam logic [1:0] MODE_PIN_PROG   = 2'h2;

    typedef enum logic [2:0] {
        LSPC_MODE_GS   = 3'b001,
        LSPC_MODE_DC   = 3'b010,
        LSPC_MODE_PROG = 3'b100
    } lspc_mode_type;

    typedef struct packed {
        logic       force_off;
        logic       latch;
        logic       shift_clk;
        logic       serial_in;
        logic       pwm_clk;
        logic       dc_source;
        logic [1:0] mode_pin;
        logic       open_led;
        logic       thermal;
    } lspc_pins_type;

endpackage

// [logic/lspc_sync.sv]
`timescale 1ns/1ps

module lspc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    // The first stage feeds only the second one; nothing else may look at it.
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule // lspc_sync

// [test/lspc_ctrl_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Serial controller on the far side of the pins
// ------------------------------------------------------------
// The shift clock stands low between frames, and the data line then shows the inverse of the last bit.
module lspc_ctrl_model (
    input  wire logic clk_i,
    output logic      serial_shift_clock_o,
    output logic      serial_in_pin_o,
    output logic      register_latch_strobe_o,
    output logic      pwm_reference_clock_o
);
    initial begin
        serial_shift_clock_o    = 1'b0;
        serial_in_pin_o         = 1'b0;
        register_latch_strobe_o = 1'b0;
        pwm_reference_clock_o   = 1'b0;
    end

    // One bit every 8 clocks, 160 ns, set up 3 clocks before the rising edge.
    task automatic send_bit(input logic b);
        @(posedge clk_i);
        serial_in_pin_o <= b;
        repeat (3) @(posedge clk_i);
        serial_shift_clock_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        serial_shift_clock_o <= 1'b0;
    endtask

    task automatic send_gs(input logic [191:0] d);
        for (int i = 191; i >= 0; i--) begin
            send_bit(d[i]);
        end
        serial_in_pin_o <= ~d[0];
    endtask

    task automatic send_dc(input logic [95:0] d);
        for (int i = 95; i >= 0; i--) begin
            send_bit(d[i]);
        end
        serial_in_pin_o <= ~d[0];
    endtask

    task automatic latch_pulse();
        @(posedge clk_i);
        register_latch_strobe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        register_latch_strobe_o <= 1'b0;
    endtask

    // The reference clock is its own pin, apart from the shift clock.
    task automatic pwm_pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pwm_reference_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            pwm_reference_clock_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule // lspc_ctrl_model

// [test/lspc_top_asserts.sv]
`timescale 1ns/1ps

module lspc_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        output_force_off_i,
    input wire logic        register_latch_strobe_i,
    input wire logic        serial_shift_clock_i,
    input wire logic        dot_correction_source_select_i,
    input wire logic [1:0]  mode_program_select_i,
    input wire logic        open_led_detect_i,
    input wire logic        thermal_error_flag_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        irq_o,
    input wire logic        serial_out_pin_o,
    input wire logic [15:0] channel_sink_output_o,
    input wire logic [95:0] dot_correction_scale_o,
    input wire logic        error_flag_output_o,
    input wire logic        error_flag_output_oe_n_o
);
    // ------------------------------------------------------------
    // Pin and bus relations
    // ------------------------------------------------------------
    // Pins pass two synchronising stages, so level rules allow five cycles to settle.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_BLANK_OFF: assert property (output_force_off_i [*5] |-> channel_sink_output_o == 16'h0000)
        else $error("channel on while forced off");
    AST_ERR_PULL: assert property ((open_led_detect_i || thermal_error_flag_i) [*5] |-> !error_flag_output_oe_n_o)
        else $error("error pin not pulled on fault");
    AST_ERR_REL: assert property (!(open_led_detect_i || thermal_error_flag_i) [*5] |-> error_flag_output_oe_n_o)
        else $error("error pin pulled without fault");
    AST_ERR_DATA: assert property (error_flag_output_o == 1'b0)
        else $error("error pin data not low");
    AST_THERM_LAT: assert property ($rose(thermal_error_flag_i) |-> ##[3:4] !error_flag_output_oe_n_o)
        else $error("thermal fault not reported in time");
    AST_RESET_DC: assert property ($fell(rst_i) |-> dot_correction_scale_o == {16{6'h3f}})
        else $error("scaling not all ones after reset");
    AST_DC_HOLD: assert property ((!register_latch_strobe_i && dot_correction_source_select_i) [*8]
        |=> $stable(dot_correction_scale_o))
        else $error("scaling changed without latch");
    AST_SERIAL_OUT_PIN_HOLD: assert property ((!serial_shift_clock_i && $stable(mode_program_select_i)) [*8]
        |=> $stable(serial_out_pin_o))
        else $error("serial out moved without shift");
    AST_RDATA_IDLE: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read slot");
    AST_IRQ_MASK: assert property (reg_write_i && reg_addr_i == lspc_pkg::OFS_ENABLE && reg_wdata_i[5:0] == 6'h00
        |-> ##2 !irq_o)
        else $error("interrupt with all sources masked");

    COV_BLANK: cover property (output_force_off_i [*5]);
    COV_IRQ: cover property ($rose(irq_o));
    COV_READ: cover property (reg_read_i ##1 reg_rdata_o != 32'h0);
endmodule // lspc_top_asserts

bind lspc_top lspc_top_asserts i_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .output_force_off_i(output_force_off_i),
    .register_latch_strobe_i(register_latch_strobe_i), .serial_shift_clock_i(serial_shift_clock_i),
    .dot_correction_source_select_i(dot_correction_source_select_i), .mode_program_select_i(mode_program_select_i),
    .open_led_detect_i(open_led_detect_i), .thermal_error_flag_i(thermal_error_flag_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .serial_out_pin_o(serial_out_pin_o),
    .channel_sink_output_o(channel_sink_output_o), .dot_correction_scale_o(dot_correction_scale_o),
    .error_flag_output_o(error_flag_output_o), .error_flag_output_oe_n_o(error_flag_output_oe_n_o)
);

// [test/lspc_top_tb.sv]
`timescale 1ns/1ps

module lspc_top_tb;
    logic         clk_i;
    logic         rst_i;
    logic         force_off;
    logic         dc_src;
    logic [1:0]   mode;
    logic         open_led;
    logic         thermal;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    logic [31:0]  rdata;
    logic         irq;
    logic         serial_out_pin;
    logic [15:0]  chan;
    logic [95:0]  dc_scale;
    logic         err;
    logic         err_oe_n;
    logic         sclk;
    logic         serial_in_pin;
    logic         latch;
    logic         pwm_reference_clock;
    logic [191:0] gs_exp;
    logic [95:0]  dc_exp;
    int           bad_count;
    int           checks;

    lspc_ctrl_model i_ctrl (.clk_i(clk_i), .serial_shift_clock_o(sclk), .serial_in_pin_o(serial_in_pin),
        .register_latch_strobe_o(latch), .pwm_reference_clock_o(pwm_reference_clock));

    lspc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .output_force_off_i(force_off), .register_latch_strobe_i(latch),
        .serial_shift_clock_i(sclk), .serial_in_pin_i(serial_in_pin), .pwm_reference_clock_i(pwm_reference_clock),
        .dot_correction_source_select_i(dc_src), .mode_program_select_i(mode), .open_led_detect_i(open_led),
        .thermal_error_flag_i(thermal), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .serial_out_pin_o(serial_out_pin),
        .channel_sink_output_o(chan), .dot_correction_scale_o(dc_scale), .error_flag_output_o(err),
        .error_flag_output_oe_n_o(err_oe_n));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (bad_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk_reg(rdata, exp);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        #500us;
        bad_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        force_off = 1'b0;
        dc_src = 1'b0;
        mode = 2'h0;
        open_led = 1'b0;
        thermal = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        bad_count = 0;
        checks = 0;
        for (int n = 0; n < 16; n++) begin
            gs_exp[12*n +: 12] = (n == 15) ? 12'h800 : 12'(n);
            dc_exp[6*n +: 6] = 6'h20 | 6'(n);
        end
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_clk(4);
        chk_pin(96'(err_oe_n), 96'h1);
        chk_pin(dc_scale, {16{6'h3f}});
        i_ctrl.send_gs(gs_exp);
        wait_clk(8);
        chk_pin(96'(chan), 96'h0);
        chk_pin(96'(serial_out_pin), 96'h1);
        i_ctrl.latch_pulse();
        wait_clk(6);
        chk_pin(96'(chan), 96'hfffe);
        i_ctrl.pwm_pulses(3);
        wait_clk(6);
        reg_rd(lspc_pkg::OFS_STATE, 32'h0001_0003);
        chk_pin(96'(chan), 96'hfff0);
        force_off <= 1'b1;
        wait_clk(6);
        chk_pin(96'(chan), 96'h0);
        reg_rd(lspc_pkg::OFS_STATE, 32'h0011_0000);
        force_off <= 1'b0;
        wait_clk(6);
        chk_pin(96'(chan), 96'hfffe);
        mode <= 2'h1;
        dc_src <= 1'b1;
        i_ctrl.send_dc(dc_exp);
        wait_clk(8);
        chk_pin(dc_scale, 96'h0);
        chk_pin(96'(serial_out_pin), 96'h1);
        i_ctrl.latch_pulse();
        wait_clk(6);
        chk_pin(dc_scale, dc_exp);
        chk_pin(96'(chan), 96'hfffe);
        dc_src <= 1'b0;
        mode <= 2'h2;
        wait_clk(8);
        chk_pin(dc_scale, {16{6'h3f}});
        dc_src <= 1'b1;
        wait_clk(8);
        reg_rd(lspc_pkg::OFS_STATE, 32'h0004_0000);
        dc_src <= 1'b0;
        mode <= 2'h1;
        wait_clk(8);
        chk_pin(dc_scale, dc_exp);
        reg_wr(lspc_pkg::OFS_CLEAR, 32'h3f);
        reg_rd(lspc_pkg::OFS_STATUS, 32'h0);
        reg_wr(lspc_pkg::OFS_ENABLE, 32'h1);
        open_led <= 1'b1;
        wait_clk(6);
        chk_pin(96'(err_oe_n), 96'h0);
        chk_pin(96'(irq), 96'h1);
        reg_rd(lspc_pkg::OFS_STATUS, 32'h1);
        reg_wr(lspc_pkg::OFS_ENABLE, 32'h0);
        wait_clk(2);
        chk_pin(96'(irq), 96'h0);
        open_led <= 1'b0;
        thermal <= 1'b1;
        wait_clk(6);
        chk_pin(96'(err_oe_n), 96'h0);
        thermal <= 1'b0;
        wait_clk(6);
        chk_pin(96'(err_oe_n), 96'h1);
        reg_rd(lspc_pkg::OFS_STATUS, 32'h3);
        reg_wr(lspc_pkg::OFS_ENABLE, 32'h2);
        wait_clk(2);
        chk_pin(96'(irq), 96'h1);
        reg_wr(lspc_pkg::OFS_CLEAR, 32'h2);
        wait_clk(1);
        chk_pin(96'(irq), 96'h0);
        reg_rd(lspc_pkg::OFS_ENABLE, 32'h2);
        reg_rd(lspc_pkg::OFS_CLEAR, 32'h0);
        reg_rd(8'h10, 32'h0);
        conclude();
    end
endmodule // lspc_top_tb
